// File: pss_top.sv
// pad sleep state, reset cause and alive clock select register block
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module pss_top
  import pss_pkg::*;
#(
  parameter int NUM_FILTERS = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // asynchronous causes and indicators from outside
  input wire logic batteryFault,
  input wire logic softwareReset,
  input wire logic watchdogReset,
  input wire logic warmReset,
  input wire logic sleepMode,
  input wire logic referenceClockSelectPin,
  // normal-mode pad control from the gpio block, same clock
  input wire pss_pad_ctl_t normalPads,
  // per-filter alternate clock request, same clock
  input wire logic [NUM_FILTERS-1:0] irqFilterClockSelect,
  // pad and clock control outputs
  output pss_pad_ctl_t padCtl,
  output logic [31:0] peripheralPullupOff,
  output pss_clk_src_t aliveClockSource,
  output pss_clk_src_t [NUM_FILTERS-1:0] filterClockSource
);

  // refused at elaboration: the filter select word is at most 32 wide
  if (NUM_FILTERS < 1 || NUM_FILTERS > 32) begin : gBadFilters
    $error("pss_top: NUM_FILTERS must be 1 to 32");
  end

  // pin synchronisers: six asynchronous levels
  localparam int NSYNC = 6;

  logic [NSYNC-1:0] syncIn;
  logic [NSYNC-1:0] syncMeta_reg;
  logic [NSYNC-1:0] syncLvl_reg;
  logic [NSYNC-1:0] syncPrev_reg;

  assign syncIn = {referenceClockSelectPin, sleepMode, batteryFault,
                   softwareReset, watchdogReset, warmReset};

  // metastable stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (reset) begin
      syncMeta_reg <= '0;
      syncLvl_reg <= '0;
      syncPrev_reg <= '0;
    end else begin
      syncMeta_reg <= syncIn;
      syncLvl_reg <= syncMeta_reg;
      syncPrev_reg <= syncLvl_reg;
    end
  end

  wire logic warmLvl = syncLvl_reg[0];
  wire logic wdtLvl = syncLvl_reg[1];
  wire logic swLvl = syncLvl_reg[2];
  wire logic battLvl = syncLvl_reg[3];
  wire logic sleepLvl = syncLvl_reg[4];
  wire logic refPinLvl = syncLvl_reg[5];

  // rising edges of the four causes, for the interrupt status
  wire logic [PSS_NUM_EV-1:0] evRise =
    syncLvl_reg[3:0] & ~syncPrev_reg[3:0];

  // bus decode
  wire logic setupPhase = psel & ~penable;
  wire logic accessDone = psel & penable & pready;
  wire logic wrDone = accessDone & pwrite;

  wire logic selPeriPu = (paddr == PSS_PERI_PU_ADDR);
  wire logic selAlive = (paddr == PSS_ALIVE_ADDR);
  wire logic selSlpDat = (paddr == PSS_SLP_DAT_ADDR);
  wire logic selSlpOen = (paddr == PSS_SLP_OEN_ADDR);
  wire logic selSlpPu = (paddr == PSS_SLP_PU_ADDR);
  wire logic selIrqStat = (paddr == PSS_IRQ_STAT_ADDR);
  wire logic selIrqClr = (paddr == PSS_IRQ_CLR_ADDR);
  wire logic selIrqEn = (paddr == PSS_IRQ_EN_ADDR);
  wire logic addrHit = selPeriPu | selAlive | selSlpDat | selSlpOen
                     | selSlpPu | selIrqStat | selIrqClr | selIrqEn;

  // status is read only and clear is write only
  wire logic badAccess = ~addrHit | (selIrqStat & pwrite)
                       | (selIrqClr & ~pwrite);

  wire logic wrPeriPu = wrDone & selPeriPu;
  wire logic wrAlive = wrDone & selAlive;
  wire logic wrSlpDat = wrDone & selSlpDat;
  wire logic wrSlpOen = wrDone & selSlpOen;
  wire logic wrSlpPu = wrDone & selSlpPu;
  wire logic wrIrqClr = wrDone & selIrqClr;
  wire logic wrIrqEn = wrDone & selIrqEn;

  // register storage
  logic [31:0] periPullup_reg;
  logic [31:0] periPullup_next;
  logic [31:0] aliveStatus_reg;
  logic [31:0] aliveStatus_next;
  logic [31:0] sleepData_reg;
  logic [31:0] sleepData_next;
  logic [31:0] sleepOen_reg;
  logic [31:0] sleepOen_next;
  logic [31:0] sleepPullup_reg;
  logic [31:0] sleepPullup_next;
  logic [PSS_NUM_EV-1:0] irqStatus_reg;
  logic [PSS_NUM_EV-1:0] irqStatus_next;
  logic [PSS_NUM_EV-1:0] irqEnable_reg;
  logic [PSS_NUM_EV-1:0] irqEnable_next;

  // peripheral pull-up: only the documented group bits store
  assign periPullup_next = wrPeriPu
    ? (pwdata & PSS_PERI_PU_MASK) : periPullup_reg;

  // alive register: hardware-set cause flags, software bits 1 and 0
  logic [31:0] hwSet;
  logic [31:0] aliveWritten;
  logic [31:0] hwFlagMask;

  assign hwFlagMask = 32'h000000F0;

  always_comb begin
    hwSet = '0;
    hwSet[PSS_BATT_FAULT_BIT] = battLvl;
    hwSet[PSS_SW_RST_BIT] = swLvl;
    hwSet[PSS_WDT_RST_BIT] = wdtLvl;
    hwSet[PSS_WARM_RST_BIT] = warmLvl;
  end

  // writing 0 to a cause flag clears it, writing 1 leaves it;
  // a cause still asserted in the clearing cycle wins
  assign aliveWritten = wrAlive
    ? ((pwdata & ~hwFlagMask) | (pwdata & aliveStatus_reg & hwFlagMask))
    : aliveStatus_reg;

  assign aliveStatus_next =
    (aliveWritten | hwSet) & PSS_ALIVE_MASK;

  // sleep-mode pad registers, full 32 bits
  assign sleepData_next = wrSlpDat ? pwdata : sleepData_reg;
  assign sleepOen_next = wrSlpOen ? pwdata : sleepOen_reg;
  assign sleepPullup_next = wrSlpPu ? pwdata : sleepPullup_reg;

  // interrupt status: edge sets, write-one clears, set wins over clear
  wire logic [PSS_NUM_EV-1:0] clrBits =
    wrIrqClr ? pwdata[PSS_NUM_EV-1:0] : '0;

  assign irqStatus_next = (irqStatus_reg & ~clrBits) | evRise;
  assign irqEnable_next = wrIrqEn ? pwdata[PSS_NUM_EV-1:0] : irqEnable_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      periPullup_reg <= PSS_PERI_PU_RST;
      aliveStatus_reg <= PSS_ALIVE_RST;
      sleepData_reg <= PSS_SLP_DAT_RST;
      sleepOen_reg <= PSS_SLP_OEN_RST;
      sleepPullup_reg <= PSS_SLP_PU_RST;
      irqStatus_reg <= PSS_IRQ_RST;
      irqEnable_reg <= PSS_IRQ_RST;
    end else begin
      periPullup_reg <= periPullup_next;
      aliveStatus_reg <= aliveStatus_next;
      sleepData_reg <= sleepData_next;
      sleepOen_reg <= sleepOen_next;
      sleepPullup_reg <= sleepPullup_next;
      irqStatus_reg <= irqStatus_next;
      irqEnable_reg <= irqEnable_next;
    end
  end

  // read mux, sampled in the setup cycle
  logic [31:0] rdMux;

  always_comb begin
    rdMux = '0;
    if (selPeriPu) begin
      rdMux = periPullup_reg;
    end else if (selAlive) begin
      rdMux = aliveStatus_reg;
    end else if (selSlpDat) begin
      rdMux = sleepData_reg;
    end else if (selSlpOen) begin
      rdMux = sleepOen_reg;
    end else if (selSlpPu) begin
      rdMux = sleepPullup_reg;
    end else if (selIrqStat) begin
      rdMux = {{(32-PSS_NUM_EV){1'b0}}, irqStatus_reg};
    end else if (selIrqEn) begin
      rdMux = {{(32-PSS_NUM_EV){1'b0}}, irqEnable_reg};
    end
  end

  // one wait-free access cycle: pready rises right after setup
  logic [31:0] prdata_next;
  logic pready_next;
  logic pslverr_next;

  assign pready_next = setupPhase;
  assign pslverr_next = setupPhase & badAccess;
  assign prdata_next = (setupPhase & ~pwrite & ~badAccess)
    ? rdMux : (accessDone ? '0 : prdata);

  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // level interrupt, registered from the next status and enable, so it changes in the same cycle as the status it reflects
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus_next & irqEnable_next);
    end
  end

  // alive clock selection: rtc when bit 0 set, else pin picks
  pss_clk_src_t aliveSrcNext;

  assign aliveSrcNext = aliveStatus_reg[PSS_CLK_SEL_BIT] ? PSS_CLK_RTC
    : (refPinLvl ? PSS_CLK_EXT : PSS_CLK_XTAL);

  // filter clocks follow the same choice when alternate is requested
  pss_clk_src_t [NUM_FILTERS-1:0] filterSrcNext;

  genvar f;
  generate
    for (f = 0; f < NUM_FILTERS; f++) begin : gFilter
      assign filterSrcNext[f] = irqFilterClockSelect[f]
        ? aliveSrcNext : PSS_CLK_PCLK;
    end
  endgenerate

  // pad muxing: sleep registers replace every normal source
  pss_pad_ctl_t padNext;

  always_comb begin
    if (sleepLvl) begin
      padNext.data = sleepData_reg;
      padNext.driveEn = ~sleepOen_reg;
      padNext.pullupOff = sleepPullup_reg;
    end else begin
      padNext = normalPads;
    end
  end

  // outputs registered; pads lag their sources by one cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      padCtl <= '{data: PSS_SLP_DAT_RST, driveEn: '0,
                  pullupOff: PSS_SLP_PU_RST};
      peripheralPullupOff <= PSS_PERI_PU_RST;
      aliveClockSource <= PSS_CLK_XTAL;
      filterClockSource <= '{default: PSS_CLK_PCLK};
    end else begin
      padCtl <= padNext;
      peripheralPullupOff <= periPullup_reg;
      aliveClockSource <= aliveSrcNext;
      filterClockSource <= filterSrcNext;
    end
  end

endmodule

// File: pss_pkg.sv
// constants, types and behaviour list of the pad sleep state block
// Behaviour
// - normal-mode pull-up register resets 0x00004000; bit 0 enables, 1 disables.
// - pull-up bits live at 26,24,14,13,12,11,10,9,8,4,2, one per pad group.
// - alive register resets zero, reports reset causes and holds sleep clock choice.
// - battery fault sets bit 7; zero means no fault seen.
// - software reset sets bit 6; otherwise it stays zero.
// - watchdog reset sets bit 5; otherwise it stays zero.
// - warm reset sets bit 4; otherwise it stays zero.
// - bit 0 picks sleep clock: 0 crystal or external by pin, 1 RTC.
// - hardware-set flags hold until software clears them after reading.
// - in sleep each sleep data bit drives its pin when enabled.
// - in sleep the normal output data has no effect on pins.
// - sleep enable resets all ones; 0 makes pin output, 1 high-impedance.
// - sleep pull-up resets all ones; 0 enables pull-up, 1 disables.
// - alternate filter clock chosen by reference pin and alive clock bit.
package pss_pkg;

  // register byte addresses
  localparam logic [31:0] PSS_PERI_PU_ADDR = 32'h44800040;
  localparam logic [31:0] PSS_ALIVE_ADDR = 32'h44800044;
  localparam logic [31:0] PSS_SLP_DAT_ADDR = 32'h44800048;
  localparam logic [31:0] PSS_SLP_OEN_ADDR = 32'h4480004C;
  localparam logic [31:0] PSS_SLP_PU_ADDR = 32'h44800050;
  localparam logic [31:0] PSS_IRQ_STAT_ADDR = 32'h44800080;
  localparam logic [31:0] PSS_IRQ_CLR_ADDR = 32'h44800084;
  localparam logic [31:0] PSS_IRQ_EN_ADDR = 32'h44800088;

  // reset values
  localparam logic [31:0] PSS_PERI_PU_RST = 32'h00004000;
  localparam logic [31:0] PSS_ALIVE_RST = 32'h00000000;
  localparam logic [31:0] PSS_SLP_DAT_RST = 32'h00000000;
  localparam logic [31:0] PSS_SLP_OEN_RST = 32'hFFFFFFFF;
  localparam logic [31:0] PSS_SLP_PU_RST = 32'hFFFFFFFF;
  localparam logic [3:0] PSS_IRQ_RST = 4'h0;

  // implemented bits
  localparam logic [31:0] PSS_PERI_PU_MASK = 32'h05007F14;
  localparam logic [31:0] PSS_ALIVE_MASK = 32'h000000F3;

  // alive register field positions
  localparam int PSS_BATT_FAULT_BIT = 7;
  localparam int PSS_SW_RST_BIT = 6;
  localparam int PSS_WDT_RST_BIT = 5;
  localparam int PSS_WARM_RST_BIT = 4;
  localparam int PSS_SLEEP_WAKE_BIT = 1;
  localparam int PSS_CLK_SEL_BIT = 0;

  // event index in status, clear and enable registers
  localparam int PSS_EV_WARM = 0;
  localparam int PSS_EV_WDT = 1;
  localparam int PSS_EV_SW = 2;
  localparam int PSS_EV_BATT = 3;
  localparam int PSS_NUM_EV = 4;

  typedef enum logic [1:0] {
    PSS_CLK_XTAL = 2'b00,
    PSS_CLK_EXT = 2'b01,
    PSS_CLK_RTC = 2'b10,
    PSS_CLK_PCLK = 2'b11
  } pss_clk_src_t;

  typedef struct packed {
    logic [31:0] data;
    logic [31:0] driveEn;
    logic [31:0] pullupOff;
  } pss_pad_ctl_t;

endpackage

// File: pss_top_asserts.sv
// concurrent checks on the pad sleep state block ports
`timescale 1ns/100ps
module pss_top_asserts
  import pss_pkg::*;
#(
  parameter int NUM_FILTERS = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb answer and interrupt
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic irq,
  // pad and clock side
  input wire logic sleepMode,
  input wire pss_pad_ctl_t normalPads,
  input wire logic [NUM_FILTERS-1:0] irqFilterClockSelect,
  input wire pss_pad_ctl_t padCtl,
  input wire logic [31:0] peripheralPullupOff,
  input wire pss_clk_src_t aliveClockSource,
  input wire pss_clk_src_t [NUM_FILTERS-1:0] filterClockSource
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  AST_PU_RESET: assert property (
    $fell(reset) |-> peripheralPullupOff == 32'h00004000)
    else $error("pull-up control wrong after reset");
  AST_PU_MASK: assert property (
    (peripheralPullupOff & 32'hFAFF80EB) == 32'h00000000)
    else $error("pull-up control set outside its groups");
  AST_CLK_RANGE: assert property (
    aliveClockSource != PSS_CLK_PCLK)
    else $error("alive clock shows bus clock");
  AST_FILT_PCLK: assert property (
    !irqFilterClockSelect[0] |=> filterClockSource[0] == PSS_CLK_PCLK)
    else $error("filter clock not bus clock");
  AST_FILT_ALIVE: assert property (
    irqFilterClockSelect[0] |=> filterClockSource[0] != PSS_CLK_PCLK)
    else $error("filter clock ignores alternate request");
  // synchroniser plus output register needs three quiet edges; the check asks for four
  AST_PADS_NORMAL: assert property (
    !sleepMode [*4] |=> padCtl == $past(normalPads))
    else $error("normal pads not passed through");
  AST_PADS_RESET: assert property (
    $fell(reset) |-> padCtl.driveEn == 32'h0 && padCtl.pullupOff == '1)
    else $error("pad controls wrong after reset");
  AST_ERR_DATA: assert property (
    pready && pslverr |-> prdata == 32'h00000000)
    else $error("refused access returned data");
  AST_IRQ_RESET: assert property (
    $fell(reset) |-> !irq && aliveClockSource == PSS_CLK_XTAL)
    else $error("alive state wrong after reset");
  COV_SLEEP: cover property (sleepMode [*4]);
  COV_REFUSED: cover property (pready && pslverr);
  COV_IRQ: cover property ($rose(irq));
endmodule
bind pss_top pss_top_asserts #(.NUM_FILTERS(NUM_FILTERS)) u_asserts (
  .mclk(mclk), .reset(reset), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .irq(irq), .sleepMode(sleepMode),
  .normalPads(normalPads), .irqFilterClockSelect(irqFilterClockSelect),
  .padCtl(padCtl), .peripheralPullupOff(peripheralPullupOff),
  .aliveClockSource(aliveClockSource),
  .filterClockSource(filterClockSource));

// File: tb_top.sv
// self-checking bench of the pad sleep state block
`timescale 1ns/100ps
module tb_top;
  import pss_pkg::*;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, puOff, r;
  logic pready, pslverr, irq, e, sleepMode = 0, refPin = 0;
  logic [3:0] cause = '0;
  logic [7:0] fsel = 8'h01;
  pss_pad_ctl_t normalPads = '0, padCtl;
  pss_clk_src_t aliveSrc;
  pss_clk_src_t [7:0] fSrc;
  int n_mismatch = 0, comparisons = 0;
  pss_top dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .batteryFault(cause[3]), .softwareReset(cause[2]),
    .watchdogReset(cause[1]), .warmReset(cause[0]), .sleepMode(sleepMode),
    .referenceClockSelectPin(refPin), .normalPads(normalPads),
    .irqFilterClockSelect(fsel), .padCtl(padCtl),
    .peripheralPullupOff(puOff), .aliveClockSource(aliveSrc),
    .filterClockSource(fSrc));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task report_and_stop;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [95:0] got, input logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  // inputs pass a two-stage synchroniser, so allow a margin
  task settle;
    repeat (6) @(posedge mclk);
  endtask
  task t_reset_values;
    rd(PSS_PERI_PU_ADDR, 32'h00004000);
    chk(e, 1'b0);
    rd(PSS_ALIVE_ADDR, 32'h0);
    rd(PSS_SLP_DAT_ADDR, 32'h0);
    rd(PSS_SLP_OEN_ADDR, 32'hFFFFFFFF);
    rd(PSS_SLP_PU_ADDR, 32'hFFFFFFFF);
  endtask
  task t_pullup;
    apb(1'b1, PSS_PERI_PU_ADDR, 32'hFFFFFFFF);
    rd(PSS_PERI_PU_ADDR, 32'h05007F14);
    chk(puOff, 32'h05007F14);
    apb(1'b1, PSS_PERI_PU_ADDR, 32'h0);
    rd(PSS_PERI_PU_ADDR, 32'h0);
  endtask
  task t_clock;
    apb(1'b1, PSS_ALIVE_ADDR, 32'hFFFFFFFF);
    rd(PSS_ALIVE_ADDR, 32'h00000003);
    chk(aliveSrc, 2'h2);
    chk({fSrc[7], fSrc[0]}, 4'hE);
    refPin <= 1'b1;
    apb(1'b1, PSS_ALIVE_ADDR, 32'h0);
    settle;
    chk({fSrc[0], aliveSrc}, 4'h5);
    refPin <= 1'b0;
    settle;
    chk(aliveSrc, 2'h0);
    fsel <= 8'h80;
    settle;
    chk({fSrc[7], fSrc[0]}, 4'h3);
  endtask
  task t_causes;
    for (int i = 0; i < 4; i++) begin
      cause[i] <= 1'b1;
      settle;
      cause[i] <= 1'b0;
      settle;
      rd(PSS_ALIVE_ADDR, 32'h10 << i);
      rd(PSS_IRQ_STAT_ADDR, 32'h1 << i);
      chk(irq, 1'b0);
      apb(1'b1, PSS_IRQ_EN_ADDR, 32'h1 << i);
      rd(PSS_IRQ_EN_ADDR, 32'h1 << i);
      rd(PSS_ALIVE_ADDR, 32'h10 << i);
      chk(irq, 1'b1);
      apb(1'b1, PSS_IRQ_CLR_ADDR, 32'h1 << i);
      apb(1'b1, PSS_ALIVE_ADDR, 32'h0);
      rd(PSS_ALIVE_ADDR, 32'h0);
      chk(irq, 1'b0);
      apb(1'b1, PSS_IRQ_EN_ADDR, 32'h0);
    end
  endtask
  task t_sleep;
    normalPads <= {32'h0F0F0F0F, 32'h3C3C3C3C, 32'h55AA55AA};
    apb(1'b1, PSS_SLP_DAT_ADDR, 32'hA5A5A5A5);
    apb(1'b1, PSS_SLP_OEN_ADDR, 32'h0000FFFF);
    apb(1'b1, PSS_SLP_PU_ADDR, 32'h12345678);
    chk(padCtl, {32'h0F0F0F0F, 32'h3C3C3C3C, 32'h55AA55AA});
    sleepMode <= 1'b1;
    settle;
    chk(padCtl, {32'hA5A5A5A5, 32'hFFFF0000, 32'h12345678});
    normalPads <= '1;
    settle;
    chk(padCtl, {32'hA5A5A5A5, 32'hFFFF0000, 32'h12345678});
    sleepMode <= 1'b0;
    settle;
    chk(padCtl, {96{1'b1}});
  endtask
  task t_refused;
    rd(32'h44800060, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, PSS_IRQ_STAT_ADDR, 32'hFFFFFFFF);
    chk(e, 1'b1);
    rd(PSS_IRQ_CLR_ADDR, 32'h0);
    chk(e, 1'b1);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    t_reset_values;
    t_pullup;
    t_clock;
    t_causes;
    t_sleep;
    t_refused;
    report_and_stop;
  end
  initial begin
    #40000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
